// File: rtl/opsc_cfg.svh
// Purpose: register offsets, field positions and reset values for the output pop suppression block
// Assumes: 16-bit register words, 8-bit register address
// Notes:   included by the design modules
//
// Operation
// - power management one bit 2 turns the buffered midrail reference on or off
// - midrail connects only to a disabled output with buffer and hold enabled
// - output control bits 13, 12, 10 enable midrail hold per output
// - output control bit 1 picks speaker hold resistance, 20k or 1k4
// - output control bit 0 picks line hold resistance, 20k or 1k1
// - output control bits 7, 6, 4 discharge outputs to ground via 550 ohms
`ifndef OPSC_CFG_SVH
`define OPSC_CFG_SVH

`define OPSC_ADDR_W           8
`define OPSC_DATA_W           16
`define OPSC_PWR_MGMT_ONE     8'h02
`define OPSC_OUTPUT_CTRL      8'h2a

`define OPSC_BIT_BUF_EN       2
`define OPSC_BIT_SPKN_HOLD    13
`define OPSC_BIT_SPKP_HOLD    12
`define OPSC_BIT_LINE_HOLD    10
`define OPSC_BIT_SPEAKER_NEG_DISCHARGE   7
`define OPSC_BIT_SPEAKER_POS_DISCHARGE   6
`define OPSC_BIT_LINE_OUT_DISCHARGE   4
`define OPSC_BIT_SPK_RSEL     1
`define OPSC_BIT_LINE_RSEL    0

`define OPSC_PWR_MASK         16'h0004
`define OPSC_OUT_MASK         16'h34d3
`define OPSC_RESET_VAL        16'h0000

`endif

// File: rtl/opsc_pkg.sv
// Purpose: types for the output pop suppression block
// Assumes: opsc_cfg.svh supplies the constants
// Notes:   output index order is speaker negative, speaker positive, line
package opsc_pkg;
  localparam int NUM_OUT = 3;

  typedef struct packed {
    logic [NUM_OUT-1:0] hold_en;
    logic [NUM_OUT-1:0] disch;
    logic               spk_rsel;
    logic               line_rsel;
    logic               buf_en;
  } opsc_ctrl_s;

  typedef struct packed {
    logic [NUM_OUT-1:0] mid_conn;
    logic [NUM_OUT-1:0] disch_on;
    logic [NUM_OUT-1:0] low_res;
    logic               buf_on;
  } opsc_sw_s;
endpackage

// File: rtl/opsc_switch.sv
// Purpose: per-output analogue switch decode
// Assumes: controls and stage enables synchronous to the clock
// Notes:   all outputs registered
`timescale 1ns/100ps
`include "opsc_cfg.svh"
module opsc_switch
  import opsc_pkg::*;
#(
  parameter int N = NUM_OUT
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire opsc_ctrl_s ctrl,
  input  wire logic [N-1:0] stage_en,
  output opsc_sw_s        sw_q
);
  opsc_sw_s sw_d;

  always_comb begin
    sw_d        = '0;
    sw_d.buf_on = ctrl.buf_en;
    sw_d.low_res = {ctrl.line_rsel, ctrl.spk_rsel, ctrl.spk_rsel};
  end

  genvar g;
  for (g = 0; g < N; g++) begin : g_out
    always_ff @(posedge clk) begin
      if (rst) begin
        sw_q.mid_conn[g] <= 1'b0;
        sw_q.disch_on[g] <= 1'b0;
      end else begin
        sw_q.disch_on[g] <= ctrl.disch[g];
        // discharge wins over hold
        sw_q.mid_conn[g] <= ~stage_en[g] & ctrl.buf_en & ctrl.hold_en[g]
                            & ~ctrl.disch[g];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_q.low_res <= '0;
      sw_q.buf_on  <= 1'b0;
    end else begin
      sw_q.low_res <= sw_d.low_res;
      sw_q.buf_on  <= sw_d.buf_on;
    end
  end

  a_mid_needs_all: assert property (@(posedge clk) disable iff (rst)
    $rose(sw_q.mid_conn[0]) |-> $past(~stage_en[0] & ctrl.buf_en & ctrl.hold_en[0]))
    else $error("midrail connected without its conditions");
  a_disch_blocks_mid: assert property (@(posedge clk) disable iff (rst)
    $past(ctrl.disch[1]) |-> !sw_q.mid_conn[1] && sw_q.disch_on[1])
    else $error("midrail connected while discharging");
  a_line_out_discharge: assert property (@(posedge clk) disable iff (rst)
    sw_q.disch_on[2] == $past(ctrl.disch[2]))
    else $error("line discharge does not follow control");
endmodule

// File: rtl/opsc_top.sv
// Purpose: register bank and switch control for output pop suppression
// Assumes: simple synchronous register port, write strobe and read strobe
// Notes:   read data valid the cycle after the read strobe
`timescale 1ns/100ps
`include "opsc_cfg.svh"
module opsc_top
  import opsc_pkg::*;
(
  input  wire logic                     REF_CLK,
  input  wire logic                     RESET,
  input  wire logic [`OPSC_ADDR_W-1:0]  REG_ADDR,
  input  wire logic [`OPSC_DATA_W-1:0]  REG_WDATA,
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  input  wire logic                     SPEAKER_NEG_STAGE_EN,
  input  wire logic                     SPEAKER_POS_STAGE_EN,
  input  wire logic                     LINE_OUTPUT_STAGE_EN,
  output logic [`OPSC_DATA_W-1:0]       REG_RDATA,
  output logic                          MIDRAIL_BUFFER_ON,
  output logic                          SPEAKER_NEG_MID_CONN,
  output logic                          SPEAKER_POS_MID_CONN,
  output logic                          LINE_OUTPUT_MID_CONN,
  output logic                          SPEAKER_NEG_DISCH_ON,
  output logic                          SPEAKER_POS_DISCH_ON,
  output logic                          LINE_OUTPUT_DISCH_ON,
  output logic                          SPEAKER_LOW_RES,
  output logic                          LINE_LOW_RES
);

  ////////////////////////////////////////////////////////////////////////
  logic [`OPSC_DATA_W-1:0] pwr_q;
  logic [`OPSC_DATA_W-1:0] out_q;
  logic [`OPSC_DATA_W-1:0] rdata_d;
  opsc_ctrl_s              ctrl;
  opsc_sw_s                sw_q;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pwr_q <= `OPSC_RESET_VAL;
    end else if (REG_WR && REG_ADDR == `OPSC_PWR_MGMT_ONE) begin
      pwr_q <= REG_WDATA & `OPSC_PWR_MASK;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      out_q <= `OPSC_RESET_VAL;
    end else if (REG_WR && REG_ADDR == `OPSC_OUTPUT_CTRL) begin
      out_q <= REG_WDATA & `OPSC_OUT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (REG_ADDR)
      `OPSC_PWR_MGMT_ONE: rdata_d = pwr_q;
      `OPSC_OUTPUT_CTRL:  rdata_d = out_q;
      default:            rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctrl.buf_en    = pwr_q[`OPSC_BIT_BUF_EN];
    ctrl.hold_en   = {out_q[`OPSC_BIT_LINE_HOLD], out_q[`OPSC_BIT_SPKP_HOLD],
                      out_q[`OPSC_BIT_SPKN_HOLD]};
    ctrl.disch     = {out_q[`OPSC_BIT_LINE_OUT_DISCHARGE], out_q[`OPSC_BIT_SPEAKER_POS_DISCHARGE],
                      out_q[`OPSC_BIT_SPEAKER_NEG_DISCHARGE]};
    ctrl.spk_rsel  = out_q[`OPSC_BIT_SPK_RSEL];
    ctrl.line_rsel = out_q[`OPSC_BIT_LINE_RSEL];
  end

  opsc_switch #(
    .N (NUM_OUT)
  ) u_switch (
    .clk      (REF_CLK),
    .rst      (RESET),
    .ctrl     (ctrl),
    .stage_en ({LINE_OUTPUT_STAGE_EN, SPEAKER_POS_STAGE_EN, SPEAKER_NEG_STAGE_EN}),
    .sw_q     (sw_q)
  );

  always_comb begin
    MIDRAIL_BUFFER_ON    = sw_q.buf_on;
    SPEAKER_NEG_MID_CONN = sw_q.mid_conn[0];
    SPEAKER_POS_MID_CONN = sw_q.mid_conn[1];
    LINE_OUTPUT_MID_CONN = sw_q.mid_conn[2];
    SPEAKER_NEG_DISCH_ON = sw_q.disch_on[0];
    SPEAKER_POS_DISCH_ON = sw_q.disch_on[1];
    LINE_OUTPUT_DISCH_ON = sw_q.disch_on[2];
    SPEAKER_LOW_RES      = sw_q.low_res[0];
    LINE_LOW_RES         = sw_q.low_res[2];
  end

  ////////////////////////////////////////////////////////////////////////
  a_buf_follows: assert property (@(posedge REF_CLK) disable iff (RESET)
    REG_WR && REG_ADDR == `OPSC_PWR_MGMT_ONE |-> ##2 MIDRAIL_BUFFER_ON == $past(REG_WDATA[2], 2))
    else $error("buffer enable not applied");
  a_hold_bits: assert property (@(posedge REF_CLK) disable iff (RESET)
    REG_WR && REG_ADDR == `OPSC_OUTPUT_CTRL |=> out_q[13] == $past(REG_WDATA[13])
    && out_q[12] == $past(REG_WDATA[12]) && out_q[10] == $past(REG_WDATA[10]))
    else $error("hold enables not stored");
  a_spk_res: assert property (@(posedge REF_CLK) disable iff (RESET)
    SPEAKER_LOW_RES == $past(out_q[`OPSC_BIT_SPK_RSEL]))
    else $error("speaker resistance select wrong");
  a_line_res: assert property (@(posedge REF_CLK) disable iff (RESET)
    LINE_LOW_RES == $past(out_q[`OPSC_BIT_LINE_RSEL]))
    else $error("line resistance select wrong");
  a_mid_line: assert property (@(posedge REF_CLK) disable iff (RESET)
    LINE_OUTPUT_MID_CONN |-> $past(pwr_q[2] && out_q[10] && !out_q[4] && !LINE_OUTPUT_STAGE_EN))
    else $error("line midrail connection without cause");
  a_disch_prec: assert property (@(posedge REF_CLK) disable iff (RESET)
    $past(out_q[7]) |-> SPEAKER_NEG_DISCH_ON && !SPEAKER_NEG_MID_CONN)
    else $error("discharge lost precedence");
  a_readback: assert property (@(posedge REF_CLK) disable iff (RESET)
    REG_RD && REG_ADDR == `OPSC_OUTPUT_CTRL && !REG_WR |=> REG_RDATA == out_q)
    else $error("output control readback wrong");
  a_reset_clear: assert property (@(posedge REF_CLK)
    $past(RESET) |-> pwr_q == 16'h0000 && out_q == 16'h0000)
    else $error("registers not cleared by reset");
  c_mid_line: cover property (@(posedge REF_CLK) disable iff (RESET) LINE_OUTPUT_MID_CONN);
  c_disch_spk: cover property (@(posedge REF_CLK) disable iff (RESET) SPEAKER_POS_DISCH_ON);
  c_both_req: cover property (@(posedge REF_CLK) disable iff (RESET)
    out_q[13] && out_q[7] && pwr_q[2]);
endmodule

// File: sim/opsc_stage_model.sv
// Purpose: analogue output stages facing the switch control
// Assumes: stage enables follow the request one clock late
// Notes:   bit order speaker negative, speaker positive, line
`timescale 1ns/100ps
module opsc_stage_model (
  input  wire logic       clk,
  input  wire logic [2:0] req,
  output logic      [2:0] stage_en_q
);
  // slow stage power-up, one clock behind the request
  always_ff @(posedge clk) begin
    stage_en_q <= req;
  end
endmodule

// File: sim/output_pop_suppression_control_test.sv
// Purpose: self-checking bench for the output pop suppression block
// Assumes: reads answer one clock after the strobe
// Notes:   expected results queued by the driver, compared by a monitor
`timescale 1ns/100ps
module output_pop_suppression_control_test;
  logic        clk, rst, wr, rd, sw_chk, rd_d, sw_d;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, pwr, outc;
  logic [2:0]  req, st;
  logic [8:0]  sw;
  logic [15:0] rd_q[$];
  logic [8:0]  sw_q[$];
  int          err_count, n_tests;
  integer      seed;
  opsc_stage_model stg (.clk(clk), .req(req), .stage_en_q(st));
  opsc_top dut (.REF_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .SPEAKER_NEG_STAGE_EN(st[2]), .SPEAKER_POS_STAGE_EN(st[1]),
    .LINE_OUTPUT_STAGE_EN(st[0]), .REG_RDATA(rdata), .MIDRAIL_BUFFER_ON(sw[8]),
    .SPEAKER_NEG_MID_CONN(sw[7]), .SPEAKER_POS_MID_CONN(sw[6]), .LINE_OUTPUT_MID_CONN(sw[5]),
    .SPEAKER_NEG_DISCH_ON(sw[4]), .SPEAKER_POS_DISCH_ON(sw[3]), .LINE_OUTPUT_DISCH_ON(sw[2]),
    .SPEAKER_LOW_RES(sw[1]), .LINE_LOW_RES(sw[0]));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] exp_sw();
    logic [2:0] h, d;
    h = {outc[13], outc[12], outc[10]};
    d = {outc[7], outc[6], outc[4]};
    return {pwr[2], h & ~d & ~req & {3{pwr[2]}}, d, outc[1], outc[0]};
  endfunction
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (e !== g) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 8'h02) pwr = d & 16'h0004;
    if (a == 8'h2a) outc = d & 16'h34d3;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    rd_q.push_back(e);
  endtask
  task automatic chk();
    sw_q.push_back(exp_sw());
    repeat (3) @(posedge clk);
    sw_chk <= 1'b1;
    @(posedge clk);
    sw_chk <= 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    rd_d <= rd;
    sw_d <= sw_chk;
  end
  always @(negedge clk) begin
    if (rd_d && rd_q.size() > 0) cmp("read data", rd_q.pop_front(), rdata);
    if (sw_d && sw_q.size() > 0) cmp("switches", {7'h00, sw_q.pop_front()}, {7'h00, sw});
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    err_count++;
    finish_test();
  end
  initial begin
    seed = 32'h404d;
    {rst, wr, rd, sw_chk, addr, wdata, req, pwr, outc} = '0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h02, 16'h0000);
    rd_reg(8'h2a, 16'h0000);
    chk();
    $display("test reset done");
    wr_reg(8'h2a, 16'h00d0);
    chk();
    wr_reg(8'h02, 16'hffff);
    wr_reg(8'h2a, 16'h34d3);
    chk();
    wr_reg(8'h2a, 16'hff2f);
    chk();
    rd_reg(8'h2a, outc);
    wr_reg(8'h05, 16'hffff);
    rd_reg(8'h05, 16'h0000);
    rd_reg(8'h02, 16'h0004);
    $display("test fixed patterns done");
    for (int i = 0; i < 16; i++) begin
      req <= 3'($random(seed));
      wr_reg(8'h02, 16'($random(seed)));
      wr_reg(8'h2a, 16'($random(seed)));
      chk();
      rd_reg(8'h2a, outc);
    end
    $display("test random done");
    wr_reg(8'h2a, 16'h00d0);
    wr_reg(8'h02, 16'h0000);
    chk();
    $display("test shutdown done");
    finish_test();
  end
endmodule
